// File: dml_defs.vh
// constants shared by the diagnostic event logger files
`ifndef DML_DEFS_VH
`define DML_DEFS_VH

// ****************************************************
// history geometry
// ****************************************************
`define DML_DEPTH 250
`define DML_LAST_SLOT 8'hF9
`define DML_HIST_SUB0 8'h06

// ****************************************************
// register byte offsets
// ****************************************************
`define DML_REG_STATUS 8'h00
`define DML_REG_NEWEST 8'h04
`define DML_REG_EMCY_CTRL 8'h08
`define DML_REG_ACK 8'h0C
`define DML_REG_SEL 8'h10
`define DML_REG_E_CODE 8'h14
`define DML_REG_E_TID_FLAGS 8'h18
`define DML_REG_E_TS_LO 8'h1C
`define DML_REG_E_TS_HI 8'h20
`define DML_REG_E_PARAM 8'h24
`define DML_REG_E_STATE 8'h28
`define DML_REG_IRQ_STATUS 8'h2C
`define DML_REG_IRQ_ENABLE 8'h30
`define DML_REG_IRQ_CLEAR 8'h34

// ****************************************************
// reset values and fields
// ****************************************************
`define DML_EMCY_RESET 1'b1
`define DML_IRQ_NEW 0
`define DML_IRQ_OVERWRITE 1
`define DML_IRQ_ACKED 2
`define DML_IRQ_W 3

// flags field: entry class
`define DML_FLAG_INFO 16'h0000
`define DML_FLAG_WARNING 16'h0001
`define DML_FLAG_ERROR 16'h0002

// text id class digit
`define DML_CLASS_WARNING 4'h4
`define DML_CLASS_ERROR 4'h8

// state machine codes
`define DML_ST_INIT 4'h1
`define DML_ST_PREOP 4'h2
`define DML_ST_SAFEOP 4'h4
`define DML_ST_OP 4'h8

// text ids of state changes
`define DML_TID_INIT_PREOP 16'h1012
`define DML_TID_PREOP_SAFEOP 16'h1024
`define DML_TID_SAFEOP_OP 16'h1048
`define DML_TID_PREOP_INIT 16'h1021
`define DML_TID_SAFEOP_PREOP 16'h1042
`define DML_TID_OP_SAFEOP 16'h1084

// diag code given to state change entries
`define DML_ESM_DIAG_CODE 32'h0000E000

`endif

// File: dml_esm_coder.v
// maps a state machine transition onto its informational text id
module dml_esm_coder (
    input wire [3:0] prev_state,
    input wire [3:0] cur_state,
    output reg change,
    output reg [15:0] text_id
);
`include "dml_defs.vh"

    always @* begin
        change = 1'b1;
        text_id = 16'h0000;
        case ({prev_state, cur_state})
            {`DML_ST_INIT, `DML_ST_PREOP}: text_id = `DML_TID_INIT_PREOP;
            {`DML_ST_PREOP, `DML_ST_SAFEOP}: text_id = `DML_TID_PREOP_SAFEOP;
            {`DML_ST_SAFEOP, `DML_ST_OP}: text_id = `DML_TID_SAFEOP_OP;
            {`DML_ST_PREOP, `DML_ST_INIT}: text_id = `DML_TID_PREOP_INIT;
            {`DML_ST_SAFEOP, `DML_ST_PREOP}: text_id = `DML_TID_SAFEOP_PREOP;
            {`DML_ST_OP, `DML_ST_SAFEOP}: text_id = `DML_TID_OP_SAFEOP;
            // other jumps carry no defined code and are not logged
            default: change = 1'b0;
        endcase
    end

endmodule // dml_esm_coder

// File: dml_logger.v
// diagnostic event logger with history, acknowledge and emergency report
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
module dml_logger (
    input wire core_clk,
    input wire srst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire ev_valid,
    input wire [31:0] ev_diag_code,
    input wire [15:0] ev_text_id,
    input wire [31:0] ev_param,
    input wire [3:0] esm_state,
    input wire [63:0] dc_time,
    input wire dc_valid,
    output reg new_entries_pending,
    output reg emcy_valid,
    output reg [15:0] emcy_text_id,
    output reg [7:0] emcy_sub_index,
    output reg irq
);
`include "dml_defs.vh"

// ****************************************************
// helpers
// ****************************************************
    localparam SCAN_IDLE = 1'b0;
    localparam SCAN_RUN = 1'b1;

    function [7:0] next_slot;
        input [7:0] idx;
        begin
            next_slot = (idx == `DML_LAST_SLOT) ? 8'h00 : idx + 8'h01;
        end
    endfunction

    function [7:0] prev_slot;
        input [7:0] idx;
        begin
            prev_slot = (idx == 8'h00) ? `DML_LAST_SLOT : idx - 8'h01;
        end
    endfunction

    // register decode shared by every write strobe
    function reg_hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            reg_hit = (addr == off);
        end
    endfunction

    // class flags follow the top hex digit of the text id
    function [15:0] class_flags;
        input [15:0] tid;
        begin
            if (tid[15:12] == `DML_CLASS_ERROR) begin
                class_flags = `DML_FLAG_ERROR;
            end else if (tid[15:12] == `DML_CLASS_WARNING) begin
                class_flags = `DML_FLAG_WARNING;
            end else begin
                class_flags = `DML_FLAG_INFO;
            end
        end
    endfunction

// ****************************************************
// history storage
// ****************************************************
    reg [31:0] mem_code [0:`DML_DEPTH-1];
    reg [15:0] mem_flags [0:`DML_DEPTH-1];
    reg [15:0] mem_tid [0:`DML_DEPTH-1];
    reg [63:0] mem_ts [0:`DML_DEPTH-1];
    reg [31:0] mem_param [0:`DML_DEPTH-1];
    reg [`DML_DEPTH-1:0] acked;

    reg [7:0] wr_ptr;
    reg [7:0] newest;
    reg [7:0] count;
    reg [63:0] local_time;
    reg [3:0] esm_prev;
    reg esm_pend;
    reg [15:0] esm_tid;
    reg [63:0] esm_ts;
    reg emcy_en;
    reg [7:0] sel;
    reg [`DML_IRQ_W-1:0] irq_status;
    reg [`DML_IRQ_W-1:0] irq_enable;
    reg scan_state;
    reg [7:0] scan_ptr;
    reg [7:0] scan_left;

    wire esm_change;
    wire [15:0] esm_code;
    wire [63:0] now_ts;
    wire wr_en;
    wire [31:0] wr_code;
    wire [15:0] wr_tid;
    wire [63:0] wr_ts;
    wire [31:0] wr_param;
    wire full;
    wire bus_take;
    wire wr_take;
    wire rd_take;
    wire ack_req;
    wire clr_req;
    wire en_req;
    wire read_newest;
    wire scan_hit;
    wire sel_ok;
    wire [`DML_IRQ_W-1:0] irq_set;
    wire [`DML_IRQ_W-1:0] next_irq_status;

    dml_esm_coder dml_esm_coder_i (
        .prev_state(esm_prev),
        .cur_state(esm_state),
        .change(esm_change),
        .text_id(esm_code)
    );

    // fall back to the free running local time without clock sync
    assign now_ts = dc_valid ? dc_time : local_time;

    // an external event has the slot; a state change waits until a cycle without one
    assign wr_en = ev_valid | esm_pend;
    assign wr_code = ev_valid ? ev_diag_code : `DML_ESM_DIAG_CODE;
    assign wr_tid = ev_valid ? ev_text_id : esm_tid;
    assign wr_ts = ev_valid ? now_ts : esm_ts;
    assign wr_param = ev_valid ? ev_param : 32'h00000000;
    assign full = (count == `DML_LAST_SLOT + 8'h01);

    assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;
    assign wr_take = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign rd_take = avs_read & ~avs_waitrequest;
    assign ack_req = wr_take & reg_hit(avs_address, `DML_REG_ACK) & avs_writedata[0];
    assign clr_req = wr_take & reg_hit(avs_address, `DML_REG_IRQ_CLEAR);
    assign en_req = wr_take & reg_hit(avs_address, `DML_REG_EMCY_CTRL);
    assign read_newest = rd_take & reg_hit(avs_address, `DML_REG_E_CODE) & (sel == newest);
    assign sel_ok = (sel <= `DML_LAST_SLOT);
    assign scan_hit = (scan_state == SCAN_RUN) && (scan_left != 8'h00) && !acked[scan_ptr];

    assign irq_set[`DML_IRQ_NEW] = wr_en;
    assign irq_set[`DML_IRQ_OVERWRITE] = wr_en & full;
    assign irq_set[`DML_IRQ_ACKED] = scan_hit;
    // a new event wins over a clear in the same cycle
    assign next_irq_status = (irq_status & ~(clr_req ? avs_writedata[`DML_IRQ_W-1:0] :
        {`DML_IRQ_W{1'b0}})) | irq_set;

// ****************************************************
// entry write
// ****************************************************
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem_code[wr_ptr] <= wr_code;
            mem_flags[wr_ptr] <= class_flags(wr_tid);
            mem_tid[wr_ptr] <= wr_tid;
            mem_ts[wr_ptr] <= wr_ts;
            mem_param[wr_ptr] <= wr_param;
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            wr_ptr <= 8'h00;
            newest <= 8'h00;
            count <= 8'h00;
            local_time <= 64'h0000000000000000;
            esm_prev <= `DML_ST_INIT;
            esm_pend <= 1'b0;
            esm_tid <= 16'h0000;
            esm_ts <= 64'h0000000000000000;
        end else begin
            local_time <= local_time + 64'h0000000000000001;
            esm_prev <= esm_state;
            if (esm_change) begin
                esm_pend <= 1'b1;
                esm_tid <= esm_code;
                esm_ts <= now_ts;
            end else if (esm_pend && !ev_valid) begin
                esm_pend <= 1'b0;
            end
            if (wr_en) begin
                newest <= wr_ptr;
                wr_ptr <= next_slot(wr_ptr);
                if (!full) begin
                    count <= count + 8'h01;
                end
            end
        end
    end

// ****************************************************
// acknowledge scan
// ****************************************************
    // walks back from the newest slot; costs up to one cycle per entry
    always @(posedge core_clk) begin
        if (srst) begin
            scan_state <= SCAN_IDLE;
            scan_ptr <= 8'h00;
            scan_left <= 8'h00;
            acked <= {`DML_DEPTH{1'b0}};
        end else begin
            case (scan_state)
                SCAN_IDLE: begin
                    if (ack_req) begin
                        scan_state <= SCAN_RUN;
                        scan_ptr <= newest;
                        scan_left <= count;
                    end
                end
                SCAN_RUN: begin
                    if (scan_left == 8'h00) begin
                        scan_state <= SCAN_IDLE;
                    end else if (!acked[scan_ptr]) begin
                        acked[scan_ptr] <= 1'b1;
                        scan_state <= SCAN_IDLE;
                    end else begin
                        scan_ptr <= prev_slot(scan_ptr);
                        scan_left <= scan_left - 8'h01;
                    end
                end
                default: scan_state <= SCAN_IDLE;
            endcase
            // a freshly written slot always starts unconfirmed
            if (wr_en) begin
                acked[wr_ptr] <= 1'b0;
            end
        end
    end

// ****************************************************
// control, pending flag and emergency report
// ****************************************************
    always @(posedge core_clk) begin
        if (srst) begin
            emcy_en <= `DML_EMCY_RESET;
            sel <= 8'h00;
            new_entries_pending <= 1'b0;
            emcy_valid <= 1'b0;
            emcy_text_id <= 16'h0000;
            emcy_sub_index <= 8'h00;
            irq_status <= {`DML_IRQ_W{1'b0}};
            irq_enable <= {`DML_IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            if (en_req) begin
                emcy_en <= avs_writedata[0];
            end
            if (wr_take && reg_hit(avs_address, `DML_REG_SEL)) begin
                sel <= avs_writedata[7:0];
            end
            if (wr_take && reg_hit(avs_address, `DML_REG_IRQ_ENABLE)) begin
                irq_enable <= avs_writedata[`DML_IRQ_W-1:0];
            end
            // reading the newest code clears it, a new entry wins
            if (wr_en) begin
                new_entries_pending <= 1'b1;
            end else if (read_newest) begin
                new_entries_pending <= 1'b0;
            end
            emcy_valid <= wr_en & emcy_en;
            if (wr_en) begin
                emcy_text_id <= wr_tid;
                emcy_sub_index <= wr_ptr + `DML_HIST_SUB0;
            end
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & irq_enable);
        end
    end

// ****************************************************
// bus slave
// ****************************************************
    // one wait cycle per access keeps the history read registered
    always @(posedge core_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
            end else begin
                avs_waitrequest <= 1'b1;
            end
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `DML_REG_STATUS: begin
                        avs_readdata <= {16'h0000, count, 6'h00,
                            scan_state, new_entries_pending};
                    end
                    `DML_REG_NEWEST: begin
                        avs_readdata <= {24'h000000,
                            (count == 8'h00) ? 8'h00 : newest + `DML_HIST_SUB0};
                    end
                    `DML_REG_EMCY_CTRL: avs_readdata <= {31'h00000000, emcy_en};
                    `DML_REG_SEL: avs_readdata <= {24'h000000, sel};
                    `DML_REG_E_CODE: avs_readdata <= mem_code[sel];
                    `DML_REG_E_TID_FLAGS: avs_readdata <= {mem_tid[sel], mem_flags[sel]};
                    `DML_REG_E_TS_LO: avs_readdata <= mem_ts[sel][31:0];
                    `DML_REG_E_TS_HI: avs_readdata <= mem_ts[sel][63:32];
                    `DML_REG_E_PARAM: avs_readdata <= mem_param[sel];
                    `DML_REG_E_STATE: begin
                        avs_readdata <= {30'h00000000, sel < count, acked[sel]};
                    end
                    `DML_REG_IRQ_STATUS: avs_readdata <= {29'h00000000, irq_status};
                    `DML_REG_IRQ_ENABLE: avs_readdata <= {29'h00000000, irq_enable};
                    default: avs_readdata <= 32'h00000000;
                endcase
                // slots past the last hold nothing; keep unknowns off the bus
                if (!sel_ok && (avs_address >= `DML_REG_E_CODE) &&
                    (avs_address <= `DML_REG_E_STATE)) begin
                    avs_readdata <= 32'h00000000;
                end
            end
        end
    end

endmodule // dml_logger

// File: dml_logger_checker.sv
// assertion checker for the diagnostic event logger ports
module dml_logger_checker (
    input wire core_clk,
    input wire srst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire ev_valid,
    input wire [31:0] ev_diag_code,
    input wire [15:0] ev_text_id,
    input wire [31:0] ev_param,
    input wire [3:0] esm_state,
    input wire [63:0] dc_time,
    input wire dc_valid,
    input wire new_entries_pending,
    input wire emcy_valid,
    input wire [15:0] emcy_text_id,
    input wire [7:0] emcy_sub_index,
    input wire irq
);
    // ****************************************************
    // bus and event relations
    // ****************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_req_answer: assert property ($rose(avs_read) || $rose(avs_write)
        |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_idle_wait: assert property (!avs_read && !avs_write |-> avs_waitrequest)
        else $error("waitrequest low with no request");
    a_pend_set: assert property (ev_valid |=> new_entries_pending)
        else $error("pending flag not set by an event");
    a_emcy_tid: assert property (ev_valid ##1 emcy_valid |->
        emcy_text_id == $past(ev_text_id))
        else $error("report text id differs from event");
    a_emcy_slot: assert property (emcy_valid |-> emcy_sub_index >= 8'h06)
        else $error("report sub-index below first history slot");
    // reset is held at least two edges in the bench, so the cleared value is already sampled
    a_emcy_hold: assert property ($changed(emcy_sub_index) |-> emcy_sub_index ==
        ((($past(emcy_sub_index) == 8'hFF) || ($past(emcy_sub_index) == 8'h00)) ? 8'h06 :
        $past(emcy_sub_index) + 8'h01))
        else $error("report sub-index jumped by more than one slot");
    a_slot_step: assert property (emcy_valid && $past(emcy_valid) |-> emcy_sub_index ==
        (($past(emcy_sub_index) == 8'hFF) ? 8'h06 : $past(emcy_sub_index) + 8'h01))
        else $error("newest slot did not advance circularly");
    c_event: cover property (ev_valid ##1 emcy_valid);
    c_read: cover property (avs_read && !avs_waitrequest);
    c_irq: cover property ($rose(irq));
endmodule // dml_logger_checker

bind dml_logger dml_logger_checker dml_logger_checker_i (.core_clk(core_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ev_valid(ev_valid),
    .ev_diag_code(ev_diag_code), .ev_text_id(ev_text_id), .ev_param(ev_param),
    .esm_state(esm_state), .dc_time(dc_time), .dc_valid(dc_valid),
    .new_entries_pending(new_entries_pending), .emcy_valid(emcy_valid),
    .emcy_text_id(emcy_text_id), .emcy_sub_index(emcy_sub_index), .irq(irq));

// File: dml_master_model.sv
// bus master model standing in for the fieldbus master
module dml_master_model (
    input wire core_clk,
    output logic [7:0] avs_address = 8'h00,
    output logic avs_read = 1'b0,
    output logic avs_write = 1'b0,
    output logic [3:0] avs_byteenable = 4'h0,
    output logic [31:0] avs_writedata = 32'h00000000,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************
    // one bus transfer
    // ****************************************************
    // request held until waitrequest is sampled low, so a slow slave is never cut short
    task xfer(input bit wr, input [7:0] a, input [31:0] d, output [31:0] q);
        begin
            @(posedge core_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_byteenable <= 4'hF;
            avs_read <= !wr;
            avs_write <= wr;
            @(posedge core_clk);
            while (avs_waitrequest) @(posedge core_clk);
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
endmodule // dml_master_model

// File: dml_logger_tb_top.sv
// testbench for the diagnostic event logger
`include "dml_defs.vh"
module dml_logger_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic ev_valid = 1'b0;
    logic dc_valid = 1'b1;
    logic [31:0] ev_diag_code = 32'h00000000;
    logic [31:0] ev_param = 32'h00000000;
    logic [15:0] ev_text_id = 16'h0000;
    logic [3:0] esm_state = 4'h1;
    logic [63:0] dc_time = 64'h0000000000000000;
    wire [7:0] avs_address;
    wire avs_read, avs_write, avs_waitrequest, new_entries_pending, emcy_valid, irq;
    wire [3:0] avs_byteenable;
    wire [31:0] avs_writedata, avs_readdata;
    wire [15:0] emcy_text_id;
    wire [7:0] emcy_sub_index;
    integer n_errors = 0;
    integer compares = 0;
    integer i;
    logic [31:0] rdat;
    logic [15:0] row_tid [0:3] = '{16'h0001, 16'h1201, 16'h4413, 16'h8100};
    logic [15:0] row_flg [0:3] = '{16'h0000, 16'h0000, 16'h0001, 16'h0002};
    logic [3:0] esm_seq [0:5] = '{4'h2, 4'h4, 4'h8, 4'h4, 4'h2, 4'h1};
    logic [15:0] esm_tid [0:5] = '{16'h1012, 16'h1024, 16'h1048, 16'h1084, 16'h1042, 16'h1021};
    always #5 core_clk = ~core_clk;
    dml_master_model dml_master_model_i (.core_clk(core_clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    dml_logger dml_logger_i (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ev_valid(ev_valid), .ev_diag_code(ev_diag_code),
        .ev_text_id(ev_text_id), .ev_param(ev_param), .esm_state(esm_state),
        .dc_time(dc_time), .dc_valid(dc_valid), .new_entries_pending(new_entries_pending),
        .emcy_valid(emcy_valid), .emcy_text_id(emcy_text_id),
        .emcy_sub_index(emcy_sub_index), .irq(irq));
    // ****************************************************
    // helpers
    // ****************************************************
    task check(input [63:0] got, input [63:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        dml_master_model_i.xfer(1'b1, a, d, rdat);
    endtask
    task rd_chk(input [7:0] a, input [31:0] exp);
        begin
            dml_master_model_i.xfer(1'b0, a, 32'h00000000, rdat);
            check(rdat, exp);
        end
    endtask
    // event data derived from the text id so the read-back can be predicted
    task fire(input [15:0] tid, input [63:0] ts);
        begin
            @(posedge core_clk);
            ev_valid <= 1'b1;
            ev_text_id <= tid;
            ev_diag_code <= {16'hC0DE, tid};
            ev_param <= {tid, 16'h0055};
            dc_time <= ts;
            @(posedge core_clk);
            ev_valid <= 1'b0;
            #1;
        end
    endtask
    task print_verdict;
        begin
            if (n_errors == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // ****************************************************
    // test sequence
    // ****************************************************
    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        rd_chk(`DML_REG_EMCY_CTRL, 32'h00000001);
        rd_chk(`DML_REG_NEWEST, 32'h00000000);
        rd_chk(8'h3C, 32'h00000000);
        wr(`DML_REG_IRQ_ENABLE, 32'h00000005);
        for (i = 0; i < 4; i = i + 1) begin
            fire(row_tid[i], {32'hA5A50000, 16'h0000, row_tid[i]});
            check(emcy_valid, 1'b1);
            check(emcy_sub_index, 8'h06 + i[7:0]);
            check(emcy_text_id, row_tid[i]);
            check(new_entries_pending, 1'b1);
            wr(`DML_REG_SEL, i);
            rd_chk(`DML_REG_E_CODE, {16'hC0DE, row_tid[i]});
            rd_chk(`DML_REG_E_TID_FLAGS, {row_tid[i], row_flg[i]});
            rd_chk(`DML_REG_E_TS_LO, {16'h0000, row_tid[i]});
            rd_chk(`DML_REG_E_TS_HI, 32'hA5A50000);
            rd_chk(`DML_REG_E_PARAM, {row_tid[i], 16'h0055});
            check(new_entries_pending, 1'b0);
        end
        check(irq, 1'b1);
        wr(`DML_REG_IRQ_CLEAR, 32'h00000007);
        rd_chk(`DML_REG_IRQ_STATUS, 32'h00000000);
        check(irq, 1'b0);
        wr(`DML_REG_IRQ_ENABLE, 32'h00000000);
        fire(16'h2001, 64'h0000000000001234);
        rd_chk(`DML_REG_IRQ_STATUS, 32'h00000001);
        check(irq, 1'b0);
        wr(`DML_REG_IRQ_ENABLE, 32'h00000004);
        wr(`DML_REG_ACK, 32'h00000001);
        do dml_master_model_i.xfer(1'b0, `DML_REG_STATUS, 32'h00000000, rdat);
        while (rdat[1]);
        wr(`DML_REG_SEL, 32'h00000004);
        rd_chk(`DML_REG_E_STATE, 32'h00000003);
        wr(`DML_REG_SEL, 32'h00000003);
        rd_chk(`DML_REG_E_STATE, 32'h00000002);
        check(irq, 1'b1);
        wr(`DML_REG_EMCY_CTRL, 32'h00000000);
        rd_chk(`DML_REG_EMCY_CTRL, 32'h00000000);
        fire(16'h4101, 64'h0000000000000001);
        check(emcy_valid, 1'b0);
        wr(`DML_REG_EMCY_CTRL, 32'h00000001);
        fire(16'h8101, 64'h0000000000000002);
        check(emcy_valid, 1'b1);
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge core_clk);
            esm_state <= esm_seq[i];
            repeat (4) @(posedge core_clk);
            rd_chk(`DML_REG_NEWEST, 8'h0D + i[7:0]);
            wr(`DML_REG_SEL, 8'h07 + i[7:0]);
            rd_chk(`DML_REG_E_TID_FLAGS, {esm_tid[i], 16'h0000});
            rd_chk(`DML_REG_E_CODE, `DML_ESM_DIAG_CODE);
        end
        @(posedge core_clk);
        for (i = 0; i < 250; i = i + 1) begin
            ev_valid <= 1'b1;
            ev_text_id <= 16'h4400 + i[15:0];
            @(posedge core_clk);
        end
        ev_valid <= 1'b0;
        dml_master_model_i.xfer(1'b0, `DML_REG_STATUS, 32'h00000000, rdat);
        check(rdat[15:8], 8'hFA);
        rd_chk(`DML_REG_NEWEST, 32'h00000012);
        dml_master_model_i.xfer(1'b0, `DML_REG_IRQ_STATUS, 32'h00000000, rdat);
        check(rdat[1], 1'b1);
        wr(`DML_REG_SEL, 32'h000000FF);
        rd_chk(`DML_REG_E_CODE, 32'h00000000);
        dc_valid <= 1'b0;
        fire(16'h1000, 64'hFFFFFFFFFFFFFFFF);
        wr(`DML_REG_SEL, 32'h0000000D);
        dc_valid <= 1'b1;
        rd_chk(`DML_REG_E_TS_HI, 32'h00000000);
        wr(`DML_REG_EMCY_CTRL, 32'h00000000);
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        check(new_entries_pending, 1'b0);
        rd_chk(`DML_REG_EMCY_CTRL, 32'h00000001);
        rd_chk(`DML_REG_NEWEST, 32'h00000000);
        print_verdict;
    end
    // generous bound: the whole sequence needs under a thousand cycles, the limit allows 50000
    initial begin
        #500000;
        n_errors = n_errors + 1;
        print_verdict;
    end
endmodule // dml_logger_tb_top
